/* File: hdl/fruc_exec.sv */
// Notes on behaviour
// RQ1: Call pushes current PC plus one first.
// RQ2: Call loads accumulator low, latch high PC.
// RQ3: Call takes two cycles, flags untouched.
// RQ4: Destination bit 0 accumulator, 1 file register.
// RQ5: Invert operand, zero flag from result.
// RQ6: Clear file register, zero flag set.
// RQ7: Decrement to destination, zero flag updated.
// RQ8: Clear accumulator, zero flag set.
// RQ9: Decrement-skip: no flags, zero result inserts no-op.
// RQ10: Increment-skip: no flags, wrap inserts no-op.
// RQ11: Other ops one cycle, nonzero skip one.
// RQ12: Increment and decrement wrap modulo 256.
`timescale 1ns/1ps
`default_nettype none
module fruc_exec (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic opValid,
  input wire fruc_pkg::fruc_op_type opCode,
  input wire logic destSel,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] fileData,
  input wire logic [7:0] accIn,
  input wire logic [6:0] upperPcLatch,
  input wire logic [14:0] pcIn,
  output logic opReady,
  output logic [7:0] resultData,
  output logic accWrite,
  output logic fileWrite,
  output logic [6:0] fileWrAddr,
  output logic zeroWrite,
  output logic zeroValue,
  output logic stackPush,
  output logic [14:0] stackTopEntry,
  output logic pcLoad,
  output logic [14:0] pcValue,
  output logic nopInsert
);
  fruc_pkg::fruc_state_type state_r, state_nxt;
  logic [7:0] res;
  logic toAcc, toFile, zWr, zVal;
  logic take;

  assign take = opValid && (state_r == fruc_pkg::FRUC_ST_EXEC);
  assign opReady = (state_r == fruc_pkg::FRUC_ST_EXEC);

  function automatic logic [7:0] step_byte(input logic [7:0] v, input logic up);
    step_byte = up ? v + fruc_pkg::ONE_BYTE : v - fruc_pkg::ONE_BYTE; // [RQ12]
  endfunction

  always_comb begin
    res = fruc_pkg::ZERO_BYTE;
    toAcc = 1'b0;
    toFile = 1'b0;
    zWr = 1'b0;
    zVal = 1'b0;
    case (opCode)
      fruc_pkg::FRUC_OP_INV: begin
        res = ~fileData; // [RQ5]
        zWr = 1'b1;
        zVal = (res == fruc_pkg::ZERO_BYTE); // [RQ5]
        toAcc = !destSel; // [RQ4]
        toFile = destSel; // [RQ4]
      end
      fruc_pkg::FRUC_OP_ZOP: begin
        res = fruc_pkg::ZERO_BYTE; // [RQ6]
        toFile = 1'b1;
        zWr = 1'b1;
        zVal = 1'b1; // [RQ6]
      end
      fruc_pkg::FRUC_OP_DEC: begin
        res = step_byte(fileData, 1'b0); // [RQ7]
        zWr = 1'b1;
        zVal = (res == fruc_pkg::ZERO_BYTE); // [RQ7]
        toAcc = !destSel;
        toFile = destSel;
      end
      fruc_pkg::FRUC_OP_ZACC: begin
        res = fruc_pkg::ZERO_BYTE; // [RQ8]
        toAcc = 1'b1;
        zWr = 1'b1;
        zVal = 1'b1; // [RQ8]
      end
      fruc_pkg::FRUC_OP_DECSKIP: begin
        res = step_byte(fileData, 1'b0); // [RQ9]
        toAcc = !destSel;
        toFile = destSel;
      end
      fruc_pkg::FRUC_OP_INCSKIP: begin
        res = step_byte(fileData, 1'b1); // [RQ10]
        toAcc = !destSel;
        toFile = destSel;
      end
      default: begin
        res = fruc_pkg::ZERO_BYTE;
      end
    endcase
  end

  always_comb begin
    state_nxt = fruc_pkg::FRUC_ST_EXEC;
    case (state_r)
      fruc_pkg::FRUC_ST_EXEC: begin
        if (opValid && opCode == fruc_pkg::FRUC_OP_CALL) begin
          state_nxt = fruc_pkg::FRUC_ST_CALL2; // [RQ3]
        end else if (opValid && (opCode == fruc_pkg::FRUC_OP_DECSKIP
            || opCode == fruc_pkg::FRUC_OP_INCSKIP) && res == fruc_pkg::ZERO_BYTE) begin
          state_nxt = fruc_pkg::FRUC_ST_SKIP2; // [RQ9] [RQ10]
        end
      end
      default: begin
        state_nxt = fruc_pkg::FRUC_ST_EXEC; // [RQ11]
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= fruc_pkg::FRUC_ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Datapath results, registered one cycle after the operation is taken
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resultData <= fruc_pkg::ZERO_BYTE;
      accWrite <= 1'b0;
      fileWrite <= 1'b0;
      fileWrAddr <= fruc_pkg::ACC_RESET;
      zeroWrite <= 1'b0;
      zeroValue <= 1'b0;
    end else begin
      resultData <= res;
      accWrite <= take && toAcc;
      fileWrite <= take && toFile;
      fileWrAddr <= fileAddr;
      zeroWrite <= take && zWr; // [RQ3]
      zeroValue <= zVal;
    end
  end

  // Call: push in the first cycle, load PC after the push
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stackPush <= 1'b0;
      stackTopEntry <= '0;
      pcLoad <= 1'b0;
      pcValue <= '0;
    end else begin
      stackPush <= take && opCode == fruc_pkg::FRUC_OP_CALL;
      if (take && opCode == fruc_pkg::FRUC_OP_CALL) begin
        stackTopEntry <= pcIn + fruc_pkg::PC_STEP; // [RQ1]
        pcValue <= {upperPcLatch, accIn}; // [RQ2]
      end
      pcLoad <= (state_r == fruc_pkg::FRUC_ST_CALL2); // [RQ2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      nopInsert <= 1'b0;
    end else begin
      nopInsert <= (state_nxt == fruc_pkg::FRUC_ST_SKIP2); // [RQ9] [RQ10]
    end
  end

  property p_call_push;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_CALL) |=> stackPush && !zeroWrite;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push"); // [RQ1]

  property p_call_value;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_CALL)
        |=> stackTopEntry == $past(pcIn) + fruc_pkg::PC_STEP;
  endproperty
  a_call_value: assert property (p_call_value) else $error("bad return address"); // [RQ1]

  property p_call_load;
    @(posedge core_clk) disable iff (!rstn)
      stackPush |=> pcLoad && opReady
        && pcValue == {$past(upperPcLatch, 2), $past(accIn, 2)};
  endproperty
  a_call_load: assert property (p_call_load) else $error("pc not loaded"); // [RQ2]

  property p_call_len;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_CALL) |=> !opReady ##1 opReady;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call not two cycles"); // [RQ3]

  property p_dest;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_DEC) |=> (accWrite != fileWrite)
        && fileWrite == $past(destSel);
  endproperty
  a_dest: assert property (p_dest) else $error("wrong destination"); // [RQ4]

  property p_clear_z;
    @(posedge core_clk) disable iff (!rstn)
      (take && (opCode == fruc_pkg::FRUC_OP_ZOP || opCode == fruc_pkg::FRUC_OP_ZACC))
        |=> zeroWrite && zeroValue && resultData == 8'h00;
  endproperty
  a_clear_z: assert property (p_clear_z) else $error("clear flag wrong"); // [RQ6]

  property p_skip_noflag;
    @(posedge core_clk) disable iff (!rstn)
      (take && (opCode == fruc_pkg::FRUC_OP_DECSKIP || opCode == fruc_pkg::FRUC_OP_INCSKIP))
        |=> !zeroWrite && (nopInsert == (resultData == 8'h00));
  endproperty
  a_skip_noflag: assert property (p_skip_noflag) else $error("skip wrong"); // [RQ9]

  property p_wrap;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_INCSKIP && fileData == 8'hff)
        |=> resultData == 8'h00 && nopInsert ##1 opReady;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment did not wrap"); // [RQ10]

  property p_single;
    @(posedge core_clk) disable iff (!rstn)
      (take && opCode == fruc_pkg::FRUC_OP_INV) |=> opReady
        && zeroValue == (resultData == 8'h00);
  endproperty
  a_single: assert property (p_single) else $error("invert not single cycle"); // [RQ11]
endmodule
`default_nettype wire

/* File: hdl/fruc_pkg.sv */
package fruc_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int ADDR_W = 7;
  localparam int LATCH_W = 7;
  localparam int ACC_PC_LSB_W = 8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [6:0] ACC_RESET = 7'h00;

  // Operation codes presented by the surrounding core's decode stage
  typedef enum logic [2:0] {
    FRUC_OP_NONE = 3'h0,
    FRUC_OP_CALL = 3'h1,
    FRUC_OP_INV = 3'h2,
    FRUC_OP_ZOP = 3'h3,
    FRUC_OP_DEC = 3'h4,
    FRUC_OP_ZACC = 3'h5,
    FRUC_OP_DECSKIP = 3'h6,
    FRUC_OP_INCSKIP = 3'h7
  } fruc_op_type;

  // Execute and second-cycle states, Gray coded along execute -> extra cycle
  typedef enum logic [1:0] {
    FRUC_ST_EXEC = 2'b00,
    FRUC_ST_CALL2 = 2'b01,
    FRUC_ST_SKIP2 = 2'b10
  } fruc_state_type;
endpackage

/* File: testbench/file_reg_unary_and_call_ops_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module file_reg_unary_and_call_ops_tb;
  logic core_clk, rstn, opValid, destSel, opReady, accWrite, fileWrite, zeroWrite;
  logic zeroValue, stackPush, pcLoad, nopInsert;
  fruc_pkg::fruc_op_type opCode;
  logic [6:0] fileAddr, upperPcLatch, fileWrAddr;
  logic [7:0] fileData, accIn, resultData;
  logic [14:0] pcIn, stackTopEntry, pcValue;
  int n_errors = 0;
  int n_checks = 0;
  integer seed = 32'hc561;
  wire [6:0] seenS = {accWrite, fileWrite, zeroWrite, stackPush, pcLoad, nopInsert, opReady};

  fruc_exec i_fruc_exec (.core_clk, .rstn, .opValid, .opCode, .destSel, .fileAddr,
    .fileData, .accIn, .upperPcLatch, .pcIn, .opReady, .resultData, .accWrite, .fileWrite,
    .fileWrAddr, .zeroWrite, .zeroValue, .stackPush, .stackTopEntry, .pcLoad, .pcValue,
    .nopInsert);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Far above the roughly 120 cycles the op sequence needs
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end

  initial begin
    int op, f, r, a, acc, lat, pc, pS, pR, pA, pP, pX, pC, pZ;
    int retStack[$];
    bit d, wa, wf, zw, nop, push;
    {rstn, opValid, destSel} = 3'h0;
    opCode = fruc_pkg::FRUC_OP_NONE;
    {fileAddr, fileData, accIn, upperPcLatch, pcIn} = 45'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    #1 check(32'(seenS), 32'h01); // idle after reset
    for (int i = 0; i <= 96; i++) begin
      @(posedge core_clk);
      op = i % 8;
      f = i < 8 ? 0 : i < 16 ? 1 : i < 24 ? 255 : $random(seed) & 255;
      d = 1'($random(seed));
      a = $random(seed) & 127;
      acc = $random(seed) & 255;
      lat = $random(seed) & 127;
      pc = $random(seed) & 32767;
      // Next op is presented at once, so a second-cycle refusal is exercised
      opValid <= (i < 96);
      opCode <= fruc_pkg::fruc_op_type'(op);
      destSel <= d;
      fileAddr <= 7'(a);
      fileData <= 8'(f);
      accIn <= 8'(acc);
      upperPcLatch <= 7'(lat);
      pcIn <= 15'(pc);
      if (i > 0) begin
        #1;
        check(32'(seenS), pS); // strobes and cycle count
        if (pS[6] || pS[5]) check(32'(resultData), pR); // result
        if (pS[5]) check(32'(fileWrAddr), pA); // file destination
        if (pS[4]) check(32'(zeroValue), pZ); // zero flag
        if (pC) check(32'(stackTopEntry), retStack[$]); // return address
        if (pX) begin
          @(posedge core_clk);
          #1 check(32'(seenS), {pC[0], 2'b01}); // second cycle, op refused
          if (pC) check(32'(pcValue), pP); // jump target
        end
      end
      {wa, wf, zw, nop, push} = 5'h0;
      r = 0;
      case (op)
        1: push = 1'b1;
        2: r = f ^ 255;
        3: wf = 1'b1;
        4, 6: r = (f + 255) % 256;
        5: wa = 1'b1;
        7: r = (f + 1) % 256;
        default: ;
      endcase
      zw = op >= 2 && op <= 5;
      nop = op >= 6 && r == 0;
      if (op == 2 || op == 4 || op >= 6) {wa, wf} = {!d, d};
      pS = {wa, wf, zw, push, 1'b0, nop, !(push || nop)};
      pX = push || nop;
      pC = push;
      pR = r;
      pA = a;
      pZ = (r == 0);
      // Model of the return stack: each call pushes the following address
      if (push) retStack.push_back((pc + 1) % 32768);
      pP = lat * 256 + acc;
    end
    print_verdict();
  end
endmodule
`default_nettype wire
